// ==== cdd_pkg.sv ====
package cdd_pkg;
   localparam int CLK_KHZ = 200000;
   localparam int RST_WIDE_MS = 20;
   localparam int RST_NARROW_MS = 1;
   localparam int RST_WIDE_CYC = RST_WIDE_MS * CLK_KHZ;
   localparam int RST_NARROW_CYC = RST_NARROW_MS * CLK_KHZ;
   // One-shot times are carried in 10 ms units, the key entry resolution.
   localparam logic [13:0] SHOT_LONG_10MS = 14'h0032;
   localparam logic [13:0] SHOT_SHORT_10MS = 14'h0005;
   localparam logic [15:0] RATE_SLOW_HZ = 16'h001e;
   localparam logic [15:0] RATE_FAST_HZ = 16'h1388;
   localparam logic [15:0] RATE_TACHO_HZ = 16'h2710;
   // Register byte offsets.
   localparam logic [7:0] KEYCFG_OFS = 8'h00;
   localparam logic [7:0] KEYTIME_OFS = 8'h04;
   localparam logic [7:0] DIPCAP_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] PANEL_OFS = 8'h10;
   // Switch positions, pin 1 in bit 0.
   localparam int SW_ENABLE = 0;
   localparam int SW_SPEED = 1;
   localparam int SW_DIR = 2;
   localparam int SW_OMODE_LO = 3;
   localparam int SW_OMODE_HI = 4;
   localparam int SW_SHOT = 5;
   localparam int SW_RWIDTH = 6;
   localparam int SW_POL = 7;
   // Encodings.
   localparam logic [2:0] IN_UP = 3'h0;
   localparam logic [2:0] IN_DOWN = 3'h1;
   localparam logic [3:0] OM_N = 4'h0;
   localparam logic [3:0] OM_F = 4'h1;
   localparam logic [3:0] OM_C = 4'h2;
   localparam logic [3:0] OM_K1 = 4'h4;
   localparam logic [2:0] FN_ONE_STAGE = 3'h0;
   localparam logic [2:0] FN_TWO_STAGE = 3'h1;
   localparam logic [2:0] FN_TOTAL = 3'h2;
   localparam logic [2:0] FN_BATCH = 3'h3;
   localparam logic [2:0] FN_TACHO = 3'h5;
   localparam logic [2:0] ITEMS_RUN = 3'h2;
   localparam logic [2:0] ITEMS_FUNC = 3'h0;
   localparam logic [2:0] ITEMS_BASIC = 3'h6;
   localparam logic [2:0] ITEMS_ADV = 3'h5;
   localparam logic [2:0] PAGE_AUX = 3'h2;
   typedef enum logic [1:0] {
      CDD_RUN   = 2'b00,
      CDD_FUNC  = 2'b01,
      CDD_BASIC = 2'b10,
      CDD_ADV   = 2'b11
   } cdd_menu_t;
   typedef struct packed {
      logic       fast;
      logic [2:0] in_mode;
      logic [3:0] out_mode;
      logic [2:0] func;
      logic       rst_narrow;
      logic       pnp;
      logic [1:0] avg;
      logic [1:0] cmp;
   } cdd_cfg_t;
   localparam cdd_cfg_t KEYCFG_RST = '{fast: 1'b0, in_mode: IN_UP, out_mode: OM_N,
      func: FN_ONE_STAGE, rst_narrow: 1'b0, pnp: 1'b0, avg: 2'h0, cmp: 2'h0};
endpackage

// ==== cdd_config_decoder.sv ====
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
// Overview of operation
// - Pin 1 OFF ignores all switches; key-entered configuration stays in force.
// - Switches are sampled only once, at power-up release.
// - Speed switch selects 30 Hz when OFF, 5 kHz when ON.
// - Direction switch selects increment when OFF, decrement when ON.
// - Pins 4 and 5 select output modes N, F, C or K-1.
// - One-shot switch selects 0.5 s when OFF, 0.05 s when ON.
// - Reset width switch selects 20 ms when OFF, 1 ms when ON.
// - Polarity switch selects sinking inputs when OFF, sourcing when ON.
// - All switches OFF behaves as switches disabled, using key defaults.
// - Default function is one-stage, or two-stage on two-output variants.
// - Reset indicator lit while reset input one or reset key is on.
// - Total indicator lit exactly while total count is displayed.
// - Batch indicator lit exactly while batch count is displayed.
// - Tachometer speed 30 Hz or 10 kHz; averaging off, 2, 4 or 8.
// - Tachometer comparison is one of four limit modes.
// - Each mode key press steps items and then operating modes.
// - At 30 Hz the count inputs get chattering suppression.
module cdd_config_decoder
   import cdd_pkg::*;
#(
   parameter bit TWO_STAGE_MODEL = 1'b0,
   parameter int RST_WIDE_CYCLES = RST_WIDE_CYC,
   parameter int RST_NARROW_CYCLES = RST_NARROW_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Register bus; every access completes without wait states.
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,

   // Front panel: configuration switch, keys and the first reset input.
   input  wire logic [7:0]  dip_switch,
   input  wire logic        mode_key,
   input  wire logic        reset_key,
   input  wire logic        reset1_in,

   // Settings in force: the captured switches while pin 1 is on, the keys for fields no switch sets; otherwise the key values.
   output logic             dip_config_active,
   output logic             count_fast,
   output logic [15:0]      max_rate_hz,
   output logic             chatter_filter_en,
   output logic [2:0]       input_mode,
   output logic [3:0]       output_mode,
   output logic [13:0]      oneshot_time_10ms,
   output logic [31:0]      reset_width_cycles,
   output logic             pnp_input,
   output logic [2:0]       counter_function,
   output logic [1:0]       avg_mode,
   output logic [1:0]       compare_mode,

   // Panel lamps and the position in the key menu.
   output logic             reset_indicator,
   output logic             total_indicator,
   output logic             batch_indicator,
   output logic [1:0]       menu_mode,
   output logic [2:0]       menu_item
);

   // Register map, one aligned 32-bit word each:
   //   0x00 key configuration, read/write, bits 16:0 in the order of cdd_cfg_t.
   //   0x04 key one-shot time in 10 ms units, read/write, bits 13:0.
   //   0x08 captured switches, read only: bit 8 capture done, bits 7:0 the pins.
   //   0x0c status, read only: time 31:18, switch mode 17, effective settings 16:0.
   //   0x10 panel, read only: lamps 7:5, menu item 4:2, operating mode 1:0.
   // Writes to the read-only words are dropped quietly; any other offset answers
   // with an error and reads as zero.

   typedef struct packed {
      logic        captured;
      logic [7:0]  dip;
      cdd_cfg_t    key;
      logic [13:0] key_time;
      cdd_cfg_t    eff;
      logic [13:0] eff_time;
      logic        dip_on;
      logic        mode_key_d;
      cdd_menu_t   menu;
      logic [2:0]  item;
      logic        rst_ind;
      logic        tot_ind;
      logic        bat_ind;
      logic [31:0] rdata;
      logic        rerr;
   } cdd_state_t;

   localparam logic [2:0] FN_DEFAULT = TWO_STAGE_MODEL ? FN_TWO_STAGE : FN_ONE_STAGE;
   localparam cdd_cfg_t KEY_RST = '{
      fast:       KEYCFG_RST.fast,
      in_mode:    KEYCFG_RST.in_mode,
      out_mode:   KEYCFG_RST.out_mode,
      func:       FN_DEFAULT,
      rst_narrow: KEYCFG_RST.rst_narrow,
      pnp:        KEYCFG_RST.pnp,
      avg:        KEYCFG_RST.avg,
      cmp:        KEYCFG_RST.cmp
   };

   // Power-on state: nothing captured yet, so the key defaults drive every output.
   localparam cdd_state_t STATE_RST = '{
      captured:   1'b0,
      dip:        8'h00,
      key:        KEY_RST,
      key_time:   SHOT_LONG_10MS,
      eff:        KEY_RST,
      eff_time:   SHOT_LONG_10MS,
      dip_on:     1'b0,
      mode_key_d: 1'b0,
      menu:       CDD_RUN,
      item:       3'h0,
      rst_ind:    1'b0,
      tot_ind:    1'b0,
      bat_ind:    1'b0,
      rdata:      32'h00000000,
      rerr:       1'b0
   };

   cdd_state_t state;
   cdd_state_t next_state;
   cdd_cfg_t   dip_cfg;
   logic [2:0] last_item;
   logic       press;
   logic       setup;
   logic       wr;
   logic       aux_page;

   // After power-on release the first edge captures the switches, the second sets
   // the switch mode and the third brings the settings to the outputs. A key write
   // reaches the outputs one edge after its access cycle; while pin 1 is on, only
   // the fields that no switch sets get through, such as the function.
   always_comb begin
      next_state = state;
      dip_cfg = state.key;
      last_item = ITEMS_RUN;
      // A press counts once on its rising edge, however long the key is held.
      press = mode_key & ~state.mode_key_d;
      setup = psel & ~penable;
      wr = psel & penable & pwrite;
      aux_page = 1'b0;

      // Sampled once on the first edge after release; later movement is ignored.
      if (!state.captured) begin
         next_state.captured = 1'b1;
         next_state.dip = dip_switch;
      end

      // Switch decode; the function itself is only ever chosen with the keys.
      dip_cfg.fast = state.dip[SW_SPEED];
      dip_cfg.rst_narrow = state.dip[SW_RWIDTH];
      dip_cfg.pnp = state.dip[SW_POL];
      // The tachometer reuses the output-mode pins for comparison and the time
      // and width pins for averaging; its times and widths come from the keys.
      if (state.key.func == FN_TACHO) begin
         dip_cfg.cmp = state.dip[SW_OMODE_HI:SW_OMODE_LO];
         dip_cfg.avg = state.dip[SW_RWIDTH:SW_SHOT];
         dip_cfg.rst_narrow = state.key.rst_narrow;
      end else begin
         dip_cfg.in_mode = state.dip[SW_DIR] ? IN_DOWN : IN_UP;
         case (state.dip[SW_OMODE_HI:SW_OMODE_LO])
            2'b00: dip_cfg.out_mode = OM_N;
            2'b01: dip_cfg.out_mode = OM_F;
            2'b10: dip_cfg.out_mode = OM_C;
            default: dip_cfg.out_mode = OM_K1;
         endcase
      end

      // Pin 1 alone decides; with all switches off the key values stand.
      next_state.dip_on = state.captured & state.dip[SW_ENABLE];
      next_state.eff = state.dip_on ? dip_cfg : state.key;
      if (state.dip_on && state.key.func != FN_TACHO) begin
         next_state.eff_time = state.dip[SW_SHOT] ? SHOT_SHORT_10MS : SHOT_LONG_10MS;
      end else begin
         next_state.eff_time = state.key_time;
      end

      // Mode key: step through items, wrap into the next operating mode.
      next_state.mode_key_d = mode_key;
      case (state.menu)
         CDD_RUN: last_item = ITEMS_RUN;
         CDD_FUNC: last_item = ITEMS_FUNC;
         CDD_BASIC: last_item = ITEMS_BASIC;
         CDD_ADV: last_item = ITEMS_ADV;
         default: last_item = ITEMS_RUN;
      endcase
      if (press) begin
         if (state.item >= last_item) begin
            next_state.item = 3'h0;
            case (state.menu)
               CDD_RUN: next_state.menu = CDD_FUNC;
               CDD_FUNC: next_state.menu = CDD_BASIC;
               CDD_BASIC: next_state.menu = CDD_ADV;
               CDD_ADV: next_state.menu = CDD_RUN;
               default: next_state.menu = CDD_RUN;
            endcase
         end else begin
            next_state.item = state.item + 3'h1;
         end
      end

      // Total and batch indicators follow the next display page so they change with it.
      aux_page = (next_state.menu == CDD_RUN) && (next_state.item == PAGE_AUX);
      next_state.rst_ind = reset1_in | reset_key;
      next_state.tot_ind = aux_page && (state.eff.func == FN_TOTAL);
      next_state.bat_ind = aux_page && (state.eff.func == FN_BATCH);

      // Key writes are kept even while pin 1 is on; the fields that no switch sets take effect at once.
      if (wr) begin
         case (paddr)
            KEYCFG_OFS: begin
               // Field order matches cdd_cfg_t, so the word maps straight across.
               next_state.key = cdd_cfg_t'(pwdata[16:0]);
            end
            KEYTIME_OFS: begin
               next_state.key_time = pwdata[13:0];
            end
            // Read-only words take no write and raise no error.
            DIPCAP_OFS, STATUS_OFS, PANEL_OFS: next_state.key_time = state.key_time;
            default: next_state.key_time = state.key_time;
         endcase
      end

      // Read data is latched in the setup cycle and shown in the access cycle.
      if (setup) begin
         next_state.rerr = 1'b0;
         case (paddr)
            KEYCFG_OFS: next_state.rdata = {15'h0000, state.key};
            KEYTIME_OFS: next_state.rdata = {18'h00000, state.key_time};
            DIPCAP_OFS: next_state.rdata = {23'h000000,
                                            state.captured,
                                            state.dip};
            STATUS_OFS: begin
               next_state.rdata = {state.eff_time, state.dip_on, state.eff};
            end
            PANEL_OFS: next_state.rdata = {24'h000000,
                                           state.bat_ind,
                                           state.tot_ind,
                                           state.rst_ind,
                                           state.item,
                                           state.menu};
            default: begin
               next_state.rdata = 32'h00000000;
               next_state.rerr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= STATE_RST;
      end else begin
         state <= next_state;
      end
   end

   assign pready = 1'b1;
   assign prdata = state.rdata;
   assign pslverr = state.rerr & psel & penable;

   assign dip_config_active = state.dip_on;
   assign count_fast = state.eff.fast;
   // The tachometer runs its fast range at a higher rate than the counter.
   always_comb begin
      if (!state.eff.fast) begin
         max_rate_hz = RATE_SLOW_HZ;
      end else if (state.eff.func == FN_TACHO) begin
         max_rate_hz = RATE_TACHO_HZ;
      end else begin
         max_rate_hz = RATE_FAST_HZ;
      end
   end
   // Contact bounce is only filtered at the slow rate; the fast rate needs clean pulses.
   assign chatter_filter_en = ~state.eff.fast;
   assign input_mode = state.eff.in_mode;
   assign output_mode = state.eff.out_mode;
   assign oneshot_time_10ms = state.eff_time;
   always_comb begin
      if (state.eff.rst_narrow) begin
         reset_width_cycles = RST_NARROW_CYCLES[31:0];
      end else begin
         reset_width_cycles = RST_WIDE_CYCLES[31:0];
      end
   end
   assign pnp_input = state.eff.pnp;
   assign counter_function = state.eff.func;
   assign avg_mode = state.eff.avg;
   assign compare_mode = state.eff.cmp;

   assign reset_indicator = state.rst_ind;
   assign total_indicator = state.tot_ind;
   assign batch_indicator = state.bat_ind;
   assign menu_mode = state.menu;
   assign menu_item = state.item;

endmodule // cdd_config_decoder

// ==== cdd_monitor.sv ====
`timescale 1ns/10ps
module cdd_monitor
   import cdd_pkg::*;
#(
   parameter int RST_WIDE_CYCLES   = 20,
   parameter int RST_NARROW_CYCLES = 4
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        mode_key,
   input wire logic        reset_key,
   input wire logic        reset1_in,
   input wire logic        dip_config_active,
   input wire logic        count_fast,
   input wire logic [15:0] max_rate_hz,
   input wire logic        chatter_filter_en,
   input wire logic [31:0] reset_width_cycles,
   input wire logic [2:0]  counter_function,
   input wire logic        reset_indicator,
   input wire logic        total_indicator,
   input wire logic        batch_indicator,
   input wire logic [1:0]  menu_mode,
   input wire logic [2:0]  menu_item
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_chatter_follows: assert property (chatter_filter_en == !count_fast)
      else $error("chatter filter does not follow speed");
   a_rate_map: assert property (max_rate_hz == (!count_fast ? RATE_SLOW_HZ :
      (counter_function == FN_TACHO) ? RATE_TACHO_HZ : RATE_FAST_HZ))
      else $error("rate does not match speed");
   a_width_legal: assert property (reset_width_cycles inside
      {RST_WIDE_CYCLES, RST_NARROW_CYCLES})
      else $error("reset width not one of two");
   // Capture settles on the second edge, so hold is judged from the fourth.
   a_capture_held: assert property ($past(presetn, 3) && $past(presetn, 2)
      && $past(presetn) |-> $stable(dip_config_active))
      else $error("switch capture moved while powered");
   a_reset_lamp: assert property ($past(presetn) |->
      reset_indicator == $past(reset1_in | reset_key))
      else $error("reset lamp wrong");
   a_total_lamp: assert property (total_indicator == (counter_function == FN_TOTAL
      && menu_mode == CDD_RUN && menu_item == PAGE_AUX))
      else $error("total lamp wrong");
   a_batch_lamp: assert property (batch_indicator == (counter_function == FN_BATCH
      && menu_mode == CDD_RUN && menu_item == PAGE_AUX))
      else $error("batch lamp wrong");
   a_key_steps: assert property ($rose(mode_key) |-> ##[1:3]
      $changed({menu_mode, menu_item}))
      else $error("mode key press did not step");
endmodule // cdd_monitor
bind cdd_config_decoder cdd_monitor #(.RST_WIDE_CYCLES(RST_WIDE_CYCLES),
   .RST_NARROW_CYCLES(RST_NARROW_CYCLES)) cdd_monitor_i (.*);

// ==== cdd_operator.sv ====
`timescale 1ns/10ps
// A press holds the key for three cycles, so it is never shorter than the
// key sampling needs and never bounces.
module cdd_operator (
   input  wire logic pclk,
   input  wire logic press,
   output logic      mode_key
);
   logic [1:0] hold = 2'h0;
   always @(posedge pclk) begin
      if (press) begin
         hold <= 2'h3;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
   end
   assign mode_key = (hold != 2'h0);
endmodule // cdd_operator

// ==== cdd_config_decoder_tb.sv ====
`timescale 1ns/10ps
module cdd_config_decoder_tb;
   import cdd_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, press, reset_key, reset1_in;
   logic        pready, pslverr, dip_config_active, count_fast, chatter_filter_en;
   logic        pnp_input, reset_indicator, total_indicator, batch_indicator, mode_key, er;
   logic [7:0]  paddr, dip_switch, lf, d;
   logic [31:0] pwdata, prdata, rd, reset_width_cycles;
   logic [15:0] max_rate_hz;
   logic [13:0] oneshot_time_10ms;
   logic [3:0]  output_mode;
   logic [2:0]  input_mode, counter_function, menu_item;
   logic [1:0]  avg_mode, compare_mode, menu_mode;
   int          n_errors, total_checks;
   logic [3:0]  omt [4] = '{OM_N, OM_F, OM_C, OM_K1};
   cdd_config_decoder #(.RST_WIDE_CYCLES(20), .RST_NARROW_CYCLES(4)) cdd_config_decoder_i (.*);
   cdd_operator cdd_operator_i (.pclk(pclk), .press(press), .mode_key(mode_key));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task boot(input logic [7:0] v);
      tick(1);
      presetn <= 1'b0;
      dip_switch <= v;
      tick(3);
      presetn <= 1'b1;
      tick(4);
   endtask
   task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k;
      tick(1);
      {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, wd};
      tick(1);
      penable <= 1'b1;
      k = 0;
      do begin
         tick(1);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k == 50) begin
         n_errors++;
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task push;
      tick(1);
      press <= 1'b1;
      tick(1);
      press <= 1'b0;
      tick(6);
      #1;
   endtask
   task exp_cfg(input logic [7:0] v);
      #1;
      chk(dip_config_active, v[0]);
      chk(max_rate_hz, v[0] & v[1] ? RATE_FAST_HZ : RATE_SLOW_HZ);
      chk(input_mode, v[0] & v[2] ? IN_DOWN : IN_UP);
      chk(output_mode, v[0] ? omt[v[4:3]] : OM_N);
      chk(oneshot_time_10ms, v[0] & v[5] ? SHOT_SHORT_10MS : SHOT_LONG_10MS);
      chk(reset_width_cycles, v[0] & v[6] ? 4 : 20);
      chk(pnp_input, v[0] & v[7]);
      chk(chatter_filter_en, !(v[0] & v[1]));
      chk(counter_function, FN_ONE_STAGE);
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, press, reset_key, reset1_in} = 7'h0;
      {paddr, dip_switch, pwdata} = 48'h0;
      n_errors = 0;
      total_checks = 0;
      lf = 8'h5c;
      // The last pass is the shipped all-off setting.
      for (int i = 0; i < 9; i++) begin
         lf = nx(lf);
         d = (i == 8) ? 8'h00 : {lf[7:5], i[1:0], lf[2:1], ~i[2]};
         boot(d);
         exp_cfg(d);
         tick(1);
         dip_switch <= ~d;
         tick(3);
         exp_cfg(d);
         apb(DIPCAP_OFS, 1'b0, 32'h0);
         chk(rd, {23'h0, 1'b1, d});
         $display("switch pass %0d done", i);
      end
      for (int e = 0; e < 2; e++) begin
         boot({7'h0, e[0]});
         apb(KEYCFG_OFS, 1'b1, {15'h0, 1'b1, IN_DOWN, OM_C, 9'h0});
         tick(2);
         #1;
         chk(count_fast, !e[0]);
         chk(output_mode, e[0] ? OM_N : OM_C);
         apb(8'h14, 1'b0, 32'h0);
         chk({er, rd[30:0]}, 32'h8000_0000);
         $display("key pass %0d done", e);
      end
      for (int t = 0; t < 2; t++) begin
         lf = nx(lf);
         d = {lf[7:2], t[0], 1'b1};
         boot(d);
         apb(KEYCFG_OFS, 1'b1, {23'h0, FN_TACHO, 6'h0});
         tick(2);
         #1;
         chk(max_rate_hz, d[1] ? RATE_TACHO_HZ : RATE_SLOW_HZ);
         chk(avg_mode, d[6:5]);
         chk(compare_mode, d[4:3]);
         chk(chatter_filter_en, !d[1]);
         chk(oneshot_time_10ms, SHOT_LONG_10MS);
         chk(reset_width_cycles, 20);
         $display("tacho pass %0d done", t);
      end
      for (int j = 0; j < 4; j++) begin
         tick(1);
         {reset_key, reset1_in} <= j[1:0];
         tick(2);
         #1;
         chk(reset_indicator, |j[1:0]);
      end
      $display("reset lamp done");
      for (int f = 0; f < 2; f++) begin
         boot(8'h00);
         apb(KEYCFG_OFS, 1'b1, {23'h0, f[0] ? FN_BATCH : FN_TOTAL, 6'h0});
         push();
         push();
         chk(menu_item, PAGE_AUX);
         chk({total_indicator, batch_indicator}, f[0] ? 2'b01 : 2'b10);
         push();
         chk(menu_mode, CDD_FUNC);
         chk({total_indicator, batch_indicator}, 2'b00);
         $display("lamp pass %0d done", f);
      end
      complete_run();
   end
endmodule // cdd_config_decoder_tb
